// File: hw/eight_bit_load_execute.sv
// Fetch, decode and execute of 8-bit transfer_op instructions with register file and flags.
// Assumes external memory answers reads combinationally on memData in the same cycle.
// Functional notes
// - Register move copies source into destination in one 4-state cycle.
// - Register field codes: A 111, B 000, C 001, D 010, E 011, H 100, L 101.
// - Immediate load writes operand byte to register, cycles of 4 then 3.
// - Pointer load reads memory at pointer pair into register, 4 then 3.
// - Prefix DD indexed load reads index plus signed displacement, 4,4,3,5,3.
// - Prefix FD does the same using the second index register.
// - Pointer store writes register to memory at pointer pair, 4 then 3.
// - Indexed store 01110r after prefix writes register at index plus displacement, 19 states.
// - No transfer changes any flag bit.
// - Machine cycles follow listed state counts in order.
`timescale 1ns/1ps
module eight_bit_load_execute (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] memData,
   output load_exec_pkg::bus_req_t bus,
   output logic [7:0] regA,
   output logic [7:0] regB,
   output logic [7:0] regC,
   output logic [7:0] regD,
   output logic [7:0] regE,
   output logic [7:0] regH,
   output logic [7:0] regL,
   output logic [7:0] flags,
   output logic [15:0] pc,
   output logic instrDone,
   output logic badOpcode
);
   typedef struct packed {
      load_exec_pkg::state_t st;
      logic [2:0] tcnt;
      logic [7:0][7:0] rf;
      logic [7:0] flags;
      logic [15:0] pc;
      logic [15:0] firstIndex;
      logic [15:0] secondIndex;
      logic useSecond;
      logic isStore;
      logic [7:0] op;
      logic [15:0] addr;
      logic done;
      logic bad;
      load_exec_pkg::bus_req_t bus;
   } state_s_t;

   state_s_t s, next_s;

   // True when a 3-bit field names a register; 110 is not a register
   function automatic logic isReg(input logic [2:0] f);
      return f != load_exec_pkg::REG_MEM;
   endfunction

   logic [2:0] dstF, srcF;
   logic lastState;
   assign dstF = memData[5:3];
   assign srcF = memData[2:0];
   assign lastState = (s.tcnt == 3'h1);

   // Single sequencer; tcnt counts down the clock states of each machine cycle
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.bad = 1'b0;
      next_s.bus.rd = 1'b0;
      next_s.bus.wr = 1'b0;
      if (!lastState) begin
         next_s.tcnt = s.tcnt - 3'h1;
      end else begin
         case (s.st)
            load_exec_pkg::ST_FETCH: begin
               next_s.pc = s.pc + 16'h1;
               next_s.tcnt = load_exec_pkg::TS_FETCH;
               if (memData == load_exec_pkg::PREFIX_FIRST || memData == load_exec_pkg::PREFIX_SECOND) begin
                  next_s.useSecond = (memData == load_exec_pkg::PREFIX_SECOND);
                  next_s.st = load_exec_pkg::ST_IDXOP;
               end else if (memData[7:6] == load_exec_pkg::GRP_MOVE && isReg(dstF) && isReg(srcF)) begin
                  next_s.rf[dstF] = s.rf[srcF];
                  next_s.done = 1'b1;
               end else if (memData[7:6] == load_exec_pkg::GRP_MOVE && isReg(dstF) && !isReg(srcF)) begin
                  next_s.op = memData;
                  next_s.isStore = 1'b0;
                  next_s.addr = {s.rf[load_exec_pkg::REG_H], s.rf[load_exec_pkg::REG_L]};
                  next_s.st = load_exec_pkg::ST_MEMRD;
                  next_s.tcnt = load_exec_pkg::TS_MEM;
               end else if (memData[7:6] == load_exec_pkg::GRP_MOVE && !isReg(dstF) && isReg(srcF)) begin
                  next_s.op = memData;
                  next_s.addr = {s.rf[load_exec_pkg::REG_H], s.rf[load_exec_pkg::REG_L]};
                  next_s.st = load_exec_pkg::ST_MEMWR;
                  next_s.tcnt = load_exec_pkg::TS_MEM;
               end else if (memData[7:6] == load_exec_pkg::GRP_IMM && srcF == load_exec_pkg::IMM_LOW
                            && isReg(dstF)) begin
                  next_s.op = memData;
                  next_s.st = load_exec_pkg::ST_IMM;
                  next_s.tcnt = load_exec_pkg::TS_MEM;
               end else begin
                  next_s.bad = 1'b1; // Outside this group: skipped as a one-byte no-op
                  next_s.done = 1'b1;
               end
            end
            load_exec_pkg::ST_IDXOP: begin
               next_s.pc = s.pc + 16'h1;
               next_s.op = memData;
               next_s.isStore = !isReg(dstF);
               if (memData[7:6] == load_exec_pkg::GRP_MOVE && (isReg(dstF) != isReg(srcF))) begin
                  next_s.st = load_exec_pkg::ST_DISP;
                  next_s.tcnt = load_exec_pkg::TS_MEM;
               end else begin
                  next_s.bad = 1'b1;
                  next_s.done = 1'b1;
                  next_s.st = load_exec_pkg::ST_FETCH;
                  next_s.tcnt = load_exec_pkg::TS_FETCH;
               end
            end
            load_exec_pkg::ST_DISP: begin
               next_s.pc = s.pc + 16'h1;
               // Sign-extended displacement added to the chosen index
               next_s.addr = (s.useSecond ? s.secondIndex : s.firstIndex) + {{8{memData[7]}}, memData};
               next_s.st = load_exec_pkg::ST_ADDR;
               next_s.tcnt = load_exec_pkg::TS_ADDR;
            end
            load_exec_pkg::ST_ADDR: begin
               next_s.st = s.isStore ? load_exec_pkg::ST_MEMWR : load_exec_pkg::ST_MEMRD;
               next_s.tcnt = load_exec_pkg::TS_MEM;
            end
            load_exec_pkg::ST_IMM: begin
               next_s.pc = s.pc + 16'h1;
               next_s.rf[s.op[5:3]] = memData;
               next_s.done = 1'b1;
               next_s.st = load_exec_pkg::ST_FETCH;
               next_s.tcnt = load_exec_pkg::TS_FETCH;
            end
            load_exec_pkg::ST_MEMRD: begin
               next_s.rf[s.op[5:3]] = memData;
               next_s.done = 1'b1;
               next_s.st = load_exec_pkg::ST_FETCH;
               next_s.tcnt = load_exec_pkg::TS_FETCH;
            end
            default: begin
               next_s.done = 1'b1; // Write strobe was held during this cycle
               next_s.st = load_exec_pkg::ST_FETCH;
               next_s.tcnt = load_exec_pkg::TS_FETCH;
            end
         endcase
      end
      // Bus request registered for the coming state; flags never written
      case (next_s.st)
         load_exec_pkg::ST_MEMRD: begin
            next_s.bus.rd = 1'b1;
            next_s.bus.addr = next_s.addr;
         end
         load_exec_pkg::ST_MEMWR: begin
            next_s.bus.wr = 1'b1;
            next_s.bus.addr = next_s.addr;
            next_s.bus.wdata = next_s.rf[next_s.op[2:0]];
         end
         load_exec_pkg::ST_ADDR: begin
            next_s.bus.addr = next_s.addr;
         end
         default: begin
            next_s.bus.rd = 1'b1;
            next_s.bus.addr = next_s.pc;
         end
      endcase
   end

   // Single state register
   always_ff @(posedge clk) begin
      if (srst) begin
         s <= '0;
         s.st <= load_exec_pkg::ST_FETCH;
         s.tcnt <= load_exec_pkg::TS_FETCH;
         s.pc <= load_exec_pkg::PC_RESET;
         s.flags <= load_exec_pkg::REG_RESET;
         s.rf <= {8{load_exec_pkg::REG_RESET}};
         s.firstIndex <= load_exec_pkg::INDEX_RESET;
         s.secondIndex <= load_exec_pkg::INDEX_RESET;
         s.bus.rd <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign bus = s.bus;
   assign regA = s.rf[load_exec_pkg::REG_A];
   assign regB = s.rf[load_exec_pkg::REG_B];
   assign regC = s.rf[load_exec_pkg::REG_C];
   assign regD = s.rf[load_exec_pkg::REG_D];
   assign regE = s.rf[load_exec_pkg::REG_E];
   assign regH = s.rf[load_exec_pkg::REG_H];
   assign regL = s.rf[load_exec_pkg::REG_L];
   assign flags = s.flags;
   assign pc = s.pc;
   assign instrDone = s.done;
   assign badOpcode = s.bad;

   // Checks
   property p_flags_hold;
      @(posedge clk) disable iff (srst) $stable(s.flags);
   endproperty
   a_flags_hold: assert property (p_flags_hold) else $error("flags changed");
   property p_move_one_cycle;
      @(posedge clk) disable iff (srst) (s.st == load_exec_pkg::ST_FETCH && s.tcnt == 3'h1 && memData[7:6] == 2'h1
         && memData[5:3] != 3'h6 && memData[2:0] != 3'h6) |=> (s.rf[$past(memData[5:3])] == $past(s.rf[memData[2:0]]));
   endproperty
   a_move_one_cycle: assert property (p_move_one_cycle) else $error("move wrong");
   property p_mem_three;
      @(posedge clk) disable iff (srst) $rose(s.st == load_exec_pkg::ST_MEMRD) |-> (s.st == load_exec_pkg::ST_MEMRD)[*3]
         ##1 s.st == load_exec_pkg::ST_FETCH;
   endproperty
   a_mem_three: assert property (p_mem_three) else $error("read cycle length");
   property p_addr_five;
      @(posedge clk) disable iff (srst) $rose(s.st == load_exec_pkg::ST_ADDR) |-> (s.st == load_exec_pkg::ST_ADDR)[*5]
         ##1 (s.st == load_exec_pkg::ST_MEMRD || s.st == load_exec_pkg::ST_MEMWR);
   endproperty
   a_addr_five: assert property (p_addr_five) else $error("address cycle length");
   property p_wr_data;
      @(posedge clk) disable iff (srst) s.bus.wr |-> s.bus.wdata == s.rf[s.op[2:0]] && s.st == load_exec_pkg::ST_MEMWR;
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("store data wrong");
   property p_imm_pc;
      @(posedge clk) disable iff (srst) (s.st == load_exec_pkg::ST_IMM && s.tcnt == 3'h1) |=> s.pc == $past(s.pc) + 16'h1;
   endproperty
   a_imm_pc: assert property (p_imm_pc) else $error("pc not advanced");
   property p_imm_load;
      @(posedge clk) disable iff (srst) (s.st == load_exec_pkg::ST_IMM && s.tcnt == 3'h1) |=> s.rf[s.op[5:3]] == $past(memData);
   endproperty
   a_imm_load: assert property (p_imm_load) else $error("immediate wrong");
   property p_disp_addr;
      @(posedge clk) disable iff (srst) (s.st == load_exec_pkg::ST_DISP && s.tcnt == 3'h1) |=> s.addr ==
         ($past(s.useSecond) ? s.secondIndex : s.firstIndex) + {{8{$past(memData[7])}}, $past(memData)};
   endproperty
   a_disp_addr: assert property (p_disp_addr) else $error("indexed address wrong");
   c_indexed: cover property (@(posedge clk) s.st == load_exec_pkg::ST_ADDR ##5 s.st == load_exec_pkg::ST_MEMRD);
   c_store: cover property (@(posedge clk) s.bus.wr);
   c_second: cover property (@(posedge clk) s.useSecond && s.st == load_exec_pkg::ST_MEMRD);
endmodule

// File: hw/load_exec_pkg.sv
// Package for the 8-bit transfer_op execute block: encodings, state timing, bus carrier.
// Assumes a single 250 MHz clock where one clock state equals one clk cycle.
package load_exec_pkg;
   // Register field codes
   localparam logic [2:0] REG_B = 3'h0;
   localparam logic [2:0] REG_C = 3'h1;
   localparam logic [2:0] REG_D = 3'h2;
   localparam logic [2:0] REG_E = 3'h3;
   localparam logic [2:0] REG_H = 3'h4;
   localparam logic [2:0] REG_L = 3'h5;
   localparam logic [2:0] REG_MEM = 3'h6;
   localparam logic [2:0] REG_A = 3'h7;
   // Prefix and opcode fields
   localparam logic [7:0] PREFIX_FIRST = 8'hdd;
   localparam logic [7:0] PREFIX_SECOND = 8'hfd;
   localparam logic [1:0] GRP_MOVE = 2'h1;
   localparam logic [1:0] GRP_IMM = 2'h0;
   localparam logic [2:0] IMM_LOW = 3'h6;
   // Clock states per machine cycle
   localparam logic [2:0] TS_FETCH = 3'h4;
   localparam logic [2:0] TS_MEM = 3'h3;
   localparam logic [2:0] TS_ADDR = 3'h5;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] INDEX_RESET = 16'hffff;
   localparam logic [7:0] REG_RESET = 8'hff;

   typedef enum logic [2:0] {
      ST_FETCH = 3'b000,
      ST_IDXOP = 3'b001,
      ST_DISP = 3'b010,
      ST_ADDR = 3'b011,
      ST_IMM = 3'b100,
      ST_MEMRD = 3'b101,
      ST_MEMWR = 3'b110
   } state_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } bus_req_t;
endpackage

// File: testbench/eight_bit_load_execute_tb.sv
// Random self-checking bench for the 8-bit transfer_op execute block.
// Assumes ext_memory as partner; program and data are preloaded at time zero.
`timescale 1ns/1ps
module eight_bit_load_execute_tb;
   typedef struct packed {
      logic [55:0] regs;
      logic [15:0] pc;
      logic [7:0] cyc;
      logic st;
      logic [15:0] sa;
      logic [7:0] sd;
      logic bad;
   } exp_t;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] memData, regA, regB, regC, regD, regE, regH, regL, flags;
   logic [15:0] pc, gpc;
   logic instrDone, badOpcode;
   load_exec_pkg::bus_req_t bus;
   int n_fail = 0;
   int cmp_count = 0;
   int cnt;
   logic [7:0] r [0:7];
   logic [7:0] em [0:65535];
   exp_t q[$];
   eight_bit_load_execute dut (.clk(clk), .srst(srst), .memData(memData), .bus(bus), .regA(regA), .regB(regB),
      .regC(regC), .regD(regD), .regE(regE), .regH(regH), .regL(regL), .flags(flags), .pc(pc),
      .instrDone(instrDone), .badOpcode(badOpcode));
   ext_memory mem_i (.clk(clk), .bus(bus), .memData(memData));
   initial forever #2 clk = ~clk;
   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Program bytes go to both the model and the bench mirror
   task automatic put(input logic [7:0] b);
      em[gpc] = b;
      mem_i.mem[gpc] = b;
      gpc++;
   endtask
   function automatic logic [2:0] pick();
      logic [2:0] v;
      v = 3'($urandom_range(0, 6));
      return (v == 3'h6) ? 3'h7 : v; // Code 110 selects no register
   endfunction
   // Append one instruction of kind k and step the bench's own register view
   task automatic gen(input int k, input logic [2:0] d, input logic [7:0] n);
      logic [2:0] s;
      logic [15:0] a;
      exp_t e;
      s = pick();
      e = '0;
      // H only by immediate with bit 7 set: pointer stays above the code
      if (k != 1 && d == 3'h4) d = 3'h5;
      if (d == 3'h4) n[7] = 1'b1;
      if (k == 5) n[7] = 1'b1; // Negative displacement keeps stores off the code
      // Positive displacement wraps into the code: only read bytes already placed
      if (k == 4 && !n[7] && 16'(n) > gpc) n = gpc[7:0];
      a = (k < 4) ? {r[4], r[5]} : load_exec_pkg::INDEX_RESET + {{8{n[7]}}, n};
      if (k >= 4 && k < 7) put((k == 4 && n[0]) ? load_exec_pkg::PREFIX_SECOND : load_exec_pkg::PREFIX_FIRST);
      case (k)
         0: begin put({2'h1, d, s}); r[d] = r[s]; e.cyc = 8'h04; end
         1: begin put({2'h0, d, 3'h6}); put(n); r[d] = n; e.cyc = 8'h07; end
         2: begin put({2'h1, d, 3'h6}); r[d] = em[a]; e.cyc = 8'h07; end
         3: begin put({5'h0e, s}); em[a] = r[s]; e.cyc = 8'h07; end
         4: begin put({2'h1, d, 3'h6}); put(n); r[d] = em[a]; e.cyc = 8'h13; end
         6: begin put(8'h00); e.cyc = 8'h08; e.bad = 1'b1; end // Prefix then a byte outside the group
         7: begin put(8'h00); e.cyc = 8'h04; e.bad = 1'b1; end // Plain byte outside the group
         default: begin put({5'h0e, s}); put(n); em[a] = r[s]; e.cyc = 8'h13; end
      endcase
      e.st = (k == 3 || k == 5);
      e.sa = a;
      e.sd = em[a];
      e.regs = {r[7], r[0], r[1], r[2], r[3], r[4], r[5]};
      e.pc = gpc;
      q.push_back(e);
   endtask
   // Watchdog sized well above 116 instructions of 19 states
   initial begin
      #40000;
      n_fail++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h0d07));
      gpc = load_exec_pkg::PC_RESET;
      foreach (r[i]) r[i] = load_exec_pkg::REG_RESET;
      for (int i = 0; i < 65536; i++) begin
         em[i] = 8'($urandom);
         mem_i.mem[i] = em[i];
      end
      // Corner cases: every register code, extreme displacements, prefix DD only
      for (int i = 0; i < 8; i++) if (i != 6) gen(1, 3'(i), 8'($urandom));
      gen(4, 3'h0, 8'h80);
      gen(4, 3'h1, 8'h00);
      gen(5, 3'h2, 8'h80);
      gen(5, 3'h3, 8'hff);
      gen(3, 3'h0, 8'h00);
      gen(2, 3'h1, 8'h00);
      for (int i = 0; i < 100; i++) gen($urandom_range(0, 5), pick(), 8'($urandom));
      // Largest positive displacement once the code has grown past its target
      gen(4, 3'h7, 8'h7f);
      gen(6, 3'h0, 8'h00);
      gen(7, 3'h0, 8'h00);
      repeat (5) @(negedge clk);
      srst = 1'b0;
      foreach (q[i]) begin
         cnt = 0;
         do begin
            @(negedge clk);
            cnt++;
         end while (instrDone !== 1'b1 && cnt < 40);
         if (i > 0) check("states", 64'(cnt), 64'(q[i].cyc));
         check("regs", 64'({regA, regB, regC, regD, regE, regH, regL}), 64'(q[i].regs));
         check("pc", 64'(pc), 64'(q[i].pc));
         check("flags", 64'(flags), 64'(load_exec_pkg::REG_RESET));
         check("badOpcode", 64'(badOpcode), 64'(q[i].bad));
         if (q[i].st) check("store", 64'(mem_i.mem[q[i].sa]), 64'(q[i].sd));
      end
      end_of_test();
   end
endmodule

// File: testbench/ext_memory.sv
// Memory model on the far side of the processor bus.
// Assumes zero-latency reads and writes taken on every rising edge while bus.wr is high.
`timescale 1ns/1ps
module ext_memory (
   input wire logic clk,
   input wire load_exec_pkg::bus_req_t bus,
   output logic [7:0] memData
);
   logic [7:0] mem [0:65535];
   logic [7:0] last;
   // Idle bus shows inverted last byte, so a stale value never passes as data
   always_comb memData = bus.rd ? mem[bus.addr] : ~last;
   // Store and remember last read; plain always because the bench preloads the array
   always @(posedge clk) begin
      if (bus.rd) last <= mem[bus.addr];
      if (bus.wr) mem[bus.addr] <= bus.wdata;
   end
endmodule
